// ---- hw/psbt_ctrl.sv ----
// Controller end: Avalon-MM registers driving burst and asynchronous accesses
//
// Decided for this implementation: the register offsets and the Avalon-MM register port.
`timescale 1ns/100ps
module psbt_ctrl #(
   parameter int AW = 22,
   parameter int MAX_LOW = psbt_pkg::MAX_SEL_LOW_CYC
) (
   // Clock and reset
   input wire logic clk,
   input wire logic resetn,
   // Avalon-MM register slave
   input wire logic [4:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // Memory link
   psbt_if.ctl bus
);
   import psbt_pkg::*;

   typedef enum {C_IDLE, C_CFG, C_AWR, C_AREL, C_ARD, C_BADR, C_BURST} psbt_cstate_type;
   localparam int CW = $clog2(MAX_LOW + 1);
   // Margin covers the registered stop so the limit itself is never reached
   localparam logic [CW-1:0] LOW_LIMIT = CW'(MAX_LOW - SEL_LOW_MARGIN);
   localparam logic [CW-1:0] CHAIN_LIMIT = CW'(MAX_LOW / 2);
   localparam logic [1:0] GAP_INIT = 2'(HIGH_GAP_CYC - 1);
   localparam logic [2:0] ASYNC_INIT = 3'(ASYNC_CYC - 1);

   psbt_cstate_type st_q, st_d;
   psbt_op_type op_q, op_d, cmd_op_q, cmd_op_d;
   logic chain_q, chain_d, cmd_pend_q, cmd_pend_d, cfg_pend_q, cfg_pend_d;
   logic resume_q, resume_d, waitreq_q, waitreq_d;
   logic [1:0] lanes_q, lanes_d, gap_q, gap_d;
   logic [AW-1:0] addr_q, addr_d, cur_q, cur_d;
   logic [15:0] wdata_q, wdata_d, cfg_q, cfg_d, rdata_q, rdata_d;
   logic [7:0] len_q, len_d, words_q, words_d;
   logic [2:0] cnt_q, cnt_d;
   logic [CW-1:0] sel_cnt_q, sel_cnt_d;
   logic [31:0] readdata_q, readdata_d;
   logic sel_n_q, sel_n_d, adv_n_q, adv_n_d, we_n_q, we_n_d, oe_n_q, oe_n_d;
   logic run_q, run_d, cfgld_q, cfgld_d, dq_oe_n_q, dq_oe_n_d;
   logic [15:0] dq_q, dq_d;
   logic req, acc, launch, chain_ok, burst_d;

   // Which moves may keep select low between two operations
   function automatic logic can_chain(input psbt_op_type prev, input psbt_op_type nxt,
                                      input logic [15:0] cfg);
      logic bp, bn;
      bp = prev inside {PSBT_OP_BRD, PSBT_OP_BWR};
      bn = nxt inside {PSBT_OP_BRD, PSBT_OP_BWR};
      if (bp && bn) begin
         return 1'b1;
      end else if (prev == PSBT_OP_AWR && nxt == PSBT_OP_BRD) begin
         return cfg[CFG_FIXED_BIT];
      end else if (prev == PSBT_OP_BRD && nxt == PSBT_OP_AWR) begin
         return cfg[CFG_FIXED_BIT];
      end else if (prev == PSBT_OP_AWR && nxt == PSBT_OP_ARD) begin
         // Writes here end on the write strobe, so only async mode needs the gap
         return cfg[CFG_SYNC_BIT];
      end
      return 1'b0;
   endfunction : can_chain

   assign req = avs_read || avs_write;
   assign acc = req && !waitreq_q;
   assign chain_ok = cmd_pend_q && chain_q && !cfg_pend_q &&
      (sel_cnt_q < CHAIN_LIMIT) && can_chain(op_q, cmd_op_q, cfg_q);

   always_comb begin
      st_d = st_q;
      op_d = op_q;
      cmd_op_d = cmd_op_q;
      chain_d = chain_q;
      cmd_pend_d = cmd_pend_q;
      cfg_pend_d = cfg_pend_q;
      resume_d = resume_q;
      lanes_d = lanes_q;
      addr_d = addr_q;
      cur_d = cur_q;
      wdata_d = wdata_q;
      cfg_d = cfg_q;
      rdata_d = rdata_q;
      len_d = len_q;
      words_d = words_q;
      cnt_d = cnt_q;
      readdata_d = readdata_q;
      launch = 1'b0;
      unique case (st_q)
         C_IDLE: begin
            if (gap_q == 2'h0) begin
               if (resume_q) begin
                  st_d = C_BADR;
                  resume_d = 1'b0;
               end else if (cfg_pend_q) begin
                  st_d = C_CFG;
                  cfg_pend_d = 1'b0;
               end else if (cmd_pend_q) begin
                  launch = 1'b1;
               end
            end
         end
         C_CFG: st_d = C_IDLE;
         C_AWR: begin
            if (cnt_q == 3'h0) begin
               st_d = C_AREL;
            end else begin
               cnt_d = cnt_q - 3'h1;
            end
         end
         C_AREL: begin
            launch = chain_ok;
            st_d = C_IDLE;
         end
         C_ARD: begin
            if (cnt_q == 3'h0) begin
               rdata_d = bus.dq;
               launch = chain_ok;
               st_d = C_IDLE;
            end else begin
               cnt_d = cnt_q - 3'h1;
            end
         end
         C_BADR: st_d = C_BURST;
         C_BURST: begin
            if (bus.wait_n) begin
               words_d = words_q + 8'h01;
               cur_d = cur_q + 1'b1;
               if (op_q == PSBT_OP_BRD) begin
                  rdata_d = bus.dq;
               end
               if (words_d >= len_q) begin
                  st_d = C_IDLE;
               end
               launch = chain_ok;
            end else if (words_q != 8'h00) begin
               launch = chain_ok;
            end
         end
      endcase
      // Force select high before the low-time limit; a burst resumes later
      if (st_q != C_IDLE && sel_cnt_q >= LOW_LIMIT) begin
         launch = 1'b0;
         st_d = C_IDLE;
         resume_d = (st_q inside {C_BADR, C_BURST}) && (words_d < len_q);
      end
      if (launch) begin
         op_d = cmd_op_q;
         cur_d = addr_q;
         words_d = 8'h00;
         cnt_d = ASYNC_INIT;
         cmd_pend_d = 1'b0;
         unique case (cmd_op_q)
            PSBT_OP_AWR: st_d = C_AWR;
            PSBT_OP_ARD: st_d = C_ARD;
            PSBT_OP_BRD, PSBT_OP_BWR: st_d = C_BADR;
         endcase
      end
      // Register slave: a new command waits while one is still pending
      waitreq_d = !(req && waitreq_q && !(avs_write && avs_address == REG_CTRL && cmd_pend_q));
      if (!waitreq_d) begin
         case (avs_address)
            REG_CTRL: readdata_d = {27'h0, lanes_q, chain_q, cmd_op_q};
            REG_ADDR: readdata_d = 32'(addr_q);
            REG_WDATA: readdata_d = {16'h0, wdata_q};
            REG_LEN: readdata_d = {24'h0, len_q};
            REG_CONFIG: readdata_d = {16'h0, cfg_q};
            REG_STATUS: readdata_d = {16'h0, words_q, 2'h0, !sel_n_q, resume_q,
                                      cfg_pend_q, cmd_pend_q, 1'b0, st_q != C_IDLE};
            REG_RDATA: readdata_d = {16'h0, rdata_q};
            default: readdata_d = 32'h0;
         endcase
      end
      if (acc && avs_write) begin
         case (avs_address)
            REG_CTRL: begin
               cmd_op_d = psbt_op_type'(avs_writedata[CTRL_OP_LSB +: 2]);
               chain_d = avs_writedata[CTRL_CHAIN_BIT];
               lanes_d = avs_writedata[CTRL_LANE_LSB +: 2];
               cmd_pend_d = 1'b1;
            end
            REG_ADDR: addr_d = avs_writedata[AW-1:0];
            REG_WDATA: wdata_d = avs_writedata[15:0];
            REG_LEN: len_d = avs_writedata[7:0];
            REG_CONFIG: begin
               cfg_d = avs_writedata[15:0];
               cfg_pend_d = 1'b1;
            end
            default: begin
            end
         endcase
      end
      // Pin levels follow the next state so every pin leaves a flip-flop
      burst_d = st_d inside {C_BADR, C_BURST};
      sel_n_d = st_d == C_IDLE;
      adv_n_d = !(st_d inside {C_BADR, C_CFG, C_AWR, C_ARD});
      we_n_d = !(st_d inside {C_AWR, C_CFG} || (st_d == C_BADR && op_d == PSBT_OP_BWR));
      oe_n_d = !(st_d == C_ARD || (st_d == C_BURST && op_d == PSBT_OP_BRD));
      run_d = burst_d;
      cfgld_d = st_d == C_CFG;
      dq_oe_n_d = !(st_d inside {C_AWR, C_CFG} || (burst_d && op_d == PSBT_OP_BWR));
      dq_d = (st_d == C_CFG) ? cfg_q : wdata_q;
      sel_cnt_d = sel_n_d ? '0 : sel_cnt_q + 1'b1;
      // One idle cycle of 20 ns covers both the refresh and the minimum gap
      if (st_d == C_IDLE && st_q != C_IDLE) begin
         gap_d = GAP_INIT;
      end else begin
         gap_d = (gap_q != 2'h0) ? gap_q - 2'h1 : 2'h0;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         st_q <= C_IDLE;
         op_q <= PSBT_OP_AWR;
         cmd_op_q <= PSBT_OP_AWR;
         chain_q <= 1'b0;
         cmd_pend_q <= 1'b0;
         cfg_pend_q <= 1'b0;
         resume_q <= 1'b0;
         waitreq_q <= 1'b1;
         lanes_q <= 2'h0;
         gap_q <= 2'h0;
         addr_q <= '0;
         cur_q <= '0;
         wdata_q <= 16'h0000;
         cfg_q <= CFG_RESET;
         rdata_q <= 16'h0000;
         len_q <= LEN_RESET;
         words_q <= 8'h00;
         cnt_q <= 3'h0;
         sel_cnt_q <= '0;
         readdata_q <= 32'h0;
         sel_n_q <= 1'b1;
         adv_n_q <= 1'b1;
         we_n_q <= 1'b1;
         oe_n_q <= 1'b1;
         run_q <= 1'b0;
         cfgld_q <= 1'b0;
         dq_oe_n_q <= 1'b1;
         dq_q <= 16'h0000;
      end else begin
         st_q <= st_d;
         op_q <= op_d;
         cmd_op_q <= cmd_op_d;
         chain_q <= chain_d;
         cmd_pend_q <= cmd_pend_d;
         cfg_pend_q <= cfg_pend_d;
         resume_q <= resume_d;
         waitreq_q <= waitreq_d;
         lanes_q <= lanes_d;
         gap_q <= gap_d;
         addr_q <= addr_d;
         cur_q <= cur_d;
         wdata_q <= wdata_d;
         cfg_q <= cfg_d;
         rdata_q <= rdata_d;
         len_q <= len_d;
         words_q <= words_d;
         cnt_q <= cnt_d;
         sel_cnt_q <= sel_cnt_d;
         readdata_q <= readdata_d;
         sel_n_q <= sel_n_d;
         adv_n_q <= adv_n_d;
         we_n_q <= we_n_d;
         oe_n_q <= oe_n_d;
         run_q <= run_d;
         cfgld_q <= cfgld_d;
         dq_oe_n_q <= dq_oe_n_d;
         dq_q <= dq_d;
      end
   end

   assign avs_readdata = readdata_q;
   assign avs_waitrequest = waitreq_q;
   assign bus.select_n = sel_n_q;
   assign bus.address_valid_n = adv_n_q;
   assign bus.write_n = we_n_q;
   assign bus.output_en_n = oe_n_q;
   assign bus.clk_run = run_q;
   assign bus.cfg_load = cfgld_q;
   assign bus.byte_lane_select_n = lanes_q;
   assign bus.addr = cur_q;
   assign bus.ctl_dq = dq_q;
   assign bus.ctl_dq_oe_n = dq_oe_n_q;
endmodule : psbt_ctrl

// ---- hw/psbt_if.sv ----
// Link between the memory controller and the pseudo-static RAM
`timescale 1ns/100ps
interface psbt_if #(parameter int AW = 22);
   logic select_n;
   logic address_valid_n;
   logic write_n;
   logic output_en_n;
   logic clk_run;
   logic cfg_load;
   logic [1:0] byte_lane_select_n;
   logic [AW-1:0] addr;
   logic [15:0] ctl_dq;
   logic ctl_dq_oe_n;
   logic [15:0] mem_dq;
   logic mem_dq_oe_n;
   logic mem_wait_n;
   logic wait_oe_n;
   logic [15:0] dq;
   logic wait_n;

   // Resolved shared wires; the stall line idles high when nobody drives it
   assign dq = !ctl_dq_oe_n ? ctl_dq : (!mem_dq_oe_n ? mem_dq : 16'h0000);
   assign wait_n = wait_oe_n ? 1'b1 : mem_wait_n;

   modport ctl (
      output select_n, address_valid_n, write_n, output_en_n, clk_run, cfg_load,
      output byte_lane_select_n, addr, ctl_dq, ctl_dq_oe_n,
      input dq, wait_n
   );
   modport mem (
      input select_n, address_valid_n, write_n, output_en_n, clk_run, cfg_load,
      input byte_lane_select_n, addr, dq,
      output mem_dq, mem_dq_oe_n, mem_wait_n, wait_oe_n
   );
endinterface : psbt_if

// ---- hw/psbt_mem.sv ----
// Memory end: small array with burst latency, stall line and hidden refresh
`timescale 1ns/100ps
module psbt_mem #(
   parameter int AW = 22,
   parameter int DEPTH_BITS = 8,
   parameter int REFRESH_CYC = psbt_pkg::REFRESH_PERIOD_CYC
) (
   // Clock and reset
   input wire logic clk,
   input wire logic resetn,
   // Memory link
   psbt_if.mem bus,
   // Local status
   output logic [15:0] cfg_word,
   output logic refresh_pending
);
   import psbt_pkg::*;

   typedef enum {M_IDLE, M_LAT, M_DATA} psbt_mstate_type;
   localparam int RW = $clog2(REFRESH_CYC);
   localparam logic [RW-1:0] RC_TOP = RW'(REFRESH_CYC - 1);

   logic [15:0] mem [2**DEPTH_BITS];
   psbt_mstate_type ph_q, ph_d;
   logic [DEPTH_BITS-1:0] a_q, a_d, aa, wa;
   logic rd_q, rd_d;
   logic [4:0] cnt_q, cnt_d, lat;
   logic wait_n_q, wait_n_d, wait_oe_n_q, wait_oe_n_d;
   logic [15:0] dq_q, dq_d, cfg_q, cfg_d;
   logic dq_oe_n_q, dq_oe_n_d;
   logic [RW-1:0] rc_q, rc_d;
   logic ref_q, ref_d;
   logic var_lat, start, wr_en;

   assign lat = psbt_latency(cfg_q);
   assign var_lat = !cfg_q[CFG_FIXED_BIT];
   assign start = !bus.select_n && bus.clk_run && !bus.address_valid_n && !bus.cfg_load;
   assign aa = bus.address_valid_n ? a_q : bus.addr[DEPTH_BITS-1:0];
   assign wa = bus.clk_run ? a_q : aa;
   // Burst words move only on edges where the stall line stood released
   assign wr_en = !bus.select_n && !bus.cfg_load &&
      ((bus.clk_run && bus.address_valid_n && ph_q == M_DATA && !rd_q && wait_n_q) ||
       (!bus.clk_run && !bus.write_n));

   always_comb begin
      ph_d = ph_q;
      a_d = a_q;
      rd_d = rd_q;
      cnt_d = cnt_q;
      wait_n_d = wait_n_q;
      dq_d = dq_q;
      dq_oe_n_d = dq_oe_n_q;
      cfg_d = cfg_q;
      ref_d = ref_q;
      rc_d = (rc_q == RC_TOP) ? '0 : rc_q + 1'b1;
      wait_oe_n_d = bus.select_n;
      if (bus.select_n) begin
         ph_d = M_IDLE;
         wait_n_d = 1'b1;
         dq_oe_n_d = 1'b1;
         ref_d = 1'b0;
      end else if (bus.cfg_load) begin
         cfg_d = bus.dq;
      end else if (start) begin
         // A new address ends any burst in flight and restarts latency
         a_d = bus.addr[DEPTH_BITS-1:0];
         rd_d = bus.write_n;
         ph_d = M_LAT;
         wait_n_d = 1'b0;
         dq_oe_n_d = 1'b1;
         if (var_lat && ref_q) begin
            cnt_d = (lat << 1) - 5'h01;
            ref_d = 1'b0;
         end else begin
            cnt_d = lat - 5'h01;
         end
      end else if (bus.clk_run) begin
         unique case (ph_q)
            M_IDLE: begin
            end
            M_LAT: begin
               if (cnt_q == 5'h00) begin
                  ph_d = M_DATA;
                  wait_n_d = 1'b1;
                  dq_d = mem[a_q];
                  dq_oe_n_d = !rd_q || bus.output_en_n;
               end else begin
                  cnt_d = cnt_q - 5'h01;
               end
            end
            M_DATA: begin
               if (wait_n_q) begin
                  a_d = a_q + 1'b1;
                  dq_d = mem[a_q + 1'b1];
                  dq_oe_n_d = !rd_q || bus.output_en_n;
               end
            end
         endcase
      end else begin
         // Asynchronous access, also entered straight from a fixed burst
         ph_d = M_IDLE;
         wait_n_d = 1'b1;
         a_d = aa;
         dq_d = mem[aa];
         dq_oe_n_d = bus.output_en_n || !bus.write_n;
      end
      // A new refresh demand wins over one taken in the same cycle
      if (rc_q == RC_TOP) begin
         ref_d = 1'b1;
      end
   end

   // Array has no reset; byte lanes gate each half
   always_ff @(posedge clk) begin
      for (int i = 0; i < 2; i++) begin
         if (wr_en && !bus.byte_lane_select_n[i]) begin
            mem[wa][i*8 +: 8] <= bus.dq[i*8 +: 8];
         end
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         ph_q <= M_IDLE;
         a_q <= '0;
         rd_q <= 1'b0;
         cnt_q <= 5'h00;
         wait_n_q <= 1'b1;
         wait_oe_n_q <= 1'b1;
         dq_q <= 16'h0000;
         dq_oe_n_q <= 1'b1;
         cfg_q <= CFG_RESET;
         rc_q <= '0;
         ref_q <= 1'b0;
      end else begin
         ph_q <= ph_d;
         a_q <= a_d;
         rd_q <= rd_d;
         cnt_q <= cnt_d;
         wait_n_q <= wait_n_d;
         wait_oe_n_q <= wait_oe_n_d;
         dq_q <= dq_d;
         dq_oe_n_q <= dq_oe_n_d;
         cfg_q <= cfg_d;
         rc_q <= rc_d;
         ref_q <= ref_d;
      end
   end

   assign bus.mem_dq = dq_q;
   assign bus.mem_dq_oe_n = dq_oe_n_q;
   assign bus.mem_wait_n = wait_n_q;
   assign bus.wait_oe_n = wait_oe_n_q;
   assign cfg_word = cfg_q;
   assign refresh_pending = ref_q;
endmodule : psbt_mem

// ---- hw/psbt_pkg.sv ----
// Shared constants and types for the pseudo-static RAM burst link
package psbt_pkg;
   localparam int CLK_PERIOD_NS = 20;
   localparam int MAX_SEL_LOW_NS = 4000;
   localparam int MAX_SEL_LOW_CYC = MAX_SEL_LOW_NS / CLK_PERIOD_NS;
   localparam int SEL_LOW_MARGIN = 4;
   localparam int REFRESH_HIGH_NS = 15;
   localparam int MIN_HIGH_GAP_NS = 5;
   localparam int REFRESH_HIGH_CYC = (REFRESH_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int MIN_HIGH_GAP_CYC = (MIN_HIGH_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int HIGH_GAP_CYC = (REFRESH_HIGH_CYC > MIN_HIGH_GAP_CYC) ?
      REFRESH_HIGH_CYC : MIN_HIGH_GAP_CYC;
   localparam int ASYNC_ACCESS_NS = 70;
   localparam int ASYNC_CYC = (ASYNC_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int REFRESH_PERIOD_CYC = 64;
   // Configuration word layout
   localparam int CFG_SYNC_BIT = 15;
   localparam int CFG_FIXED_BIT = 14;
   localparam int CFG_LAT_MSB = 13;
   localparam int CFG_LAT_LSB = 11;
   localparam logic [15:0] CFG_RESET = 16'h9000;
   localparam logic [7:0] LEN_RESET = 8'h04;
   // Register byte offsets
   localparam logic [4:0] REG_CTRL = 5'h00;
   localparam logic [4:0] REG_ADDR = 5'h04;
   localparam logic [4:0] REG_WDATA = 5'h08;
   localparam logic [4:0] REG_LEN = 5'h0c;
   localparam logic [4:0] REG_CONFIG = 5'h10;
   localparam logic [4:0] REG_STATUS = 5'h14;
   localparam logic [4:0] REG_RDATA = 5'h18;
   localparam int CTRL_OP_LSB = 0;
   localparam int CTRL_CHAIN_BIT = 2;
   localparam int CTRL_LANE_LSB = 3;

   typedef enum logic [1:0] {
      PSBT_OP_AWR = 2'h0,
      PSBT_OP_ARD = 2'h1,
      PSBT_OP_BRD = 2'h2,
      PSBT_OP_BWR = 2'h3
   } psbt_op_type;

   // Latency code n means n+1 clocks before the first word
   function automatic logic [4:0] psbt_latency(input logic [15:0] cfg);
      return {2'h0, cfg[CFG_LAT_MSB:CFG_LAT_LSB]} + 5'h01;
   endfunction : psbt_latency
endpackage : psbt_pkg

// ---- verification/psbt_burst_transition_rules_bench.sv ----
// Self-checking bench joining controller and memory
`timescale 1ns/100ps
module psbt_burst_transition_rules_bench;
   import psbt_pkg::*;
   typedef struct packed {
      logic [7:0] ctrl;
      logic [21:0] addr;
      logic [15:0] wdata;
      logic [7:0] len;
      logic [15:0] exp;
      logic go_on;
   } psbt_row_type;
   logic clk;
   logic resetn;
   logic [4:0] avs_address;
   logic avs_read;
   logic avs_write;
   logic [31:0] avs_writedata;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic [15:0] cfg_word;
   logic refresh_pending;
   logic [31:0] q;
   psbt_row_type r;
   int err_total;
   int num_checks;
   int pulses;
   // Rows with go_on set leave the next command to chain onto them;
   // the row after one reuses its address, data and length
   psbt_row_type rows [20] = '{
      '{8'h00, 22'h10, 16'ha5a5, 8'h01, 16'h0000, 1'b0},
      '{8'h01, 22'h10, 16'h0000, 8'h01, 16'ha5a5, 1'b0},
      '{8'h03, 22'h20, 16'h1234, 8'h04, 16'h0000, 1'b0},
      '{8'h02, 22'h23, 16'h0000, 8'h01, 16'h1234, 1'b0},
      '{8'h02, 22'h20, 16'h0000, 8'h00, 16'h1234, 1'b0},
      '{8'h08, 22'h10, 16'h5a5a, 8'h01, 16'h0000, 1'b0},
      '{8'h01, 22'h10, 16'h0000, 8'h01, 16'h5aa5, 1'b0},
      '{8'h00, 22'h50, 16'h6666, 8'h01, 16'h0000, 1'b1},
      '{8'h06, 22'h50, 16'h0000, 8'h01, 16'h6666, 1'b0},
      '{8'h00, 22'h30, 16'h7777, 8'h01, 16'h0000, 1'b1},
      '{8'h06, 22'h30, 16'h0000, 8'h01, 16'h7777, 1'b0},
      '{8'h02, 22'h30, 16'h4444, 8'h01, 16'h0000, 1'b1},
      '{8'h04, 22'h30, 16'h4444, 8'h01, 16'h0000, 1'b0},
      '{8'h01, 22'h30, 16'h0000, 8'h01, 16'h4444, 1'b0},
      '{8'h03, 22'h20, 16'hbeef, 8'h04, 16'h0000, 1'b1},
      '{8'h06, 22'h20, 16'h0000, 8'h04, 16'h1234, 1'b0},
      '{8'h03, 22'h100, 16'h3c3c, 8'hff, 16'h0000, 1'b0},
      '{8'h02, 22'h1fe, 16'h0000, 8'h01, 16'h3c3c, 1'b0},
      '{8'h00, 22'h60, 16'h2468, 8'h01, 16'h0000, 1'b1},
      '{8'h05, 22'h60, 16'h0000, 8'h01, 16'h2468, 1'b0}
   };
   psbt_if #(.AW(22)) psbt_if_i ();
   psbt_ctrl #(.AW(22), .MAX_LOW(MAX_SEL_LOW_CYC)) psbt_ctrl_i (
      .clk(clk), .resetn(resetn), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .bus(psbt_if_i));
   psbt_mem #(.AW(22)) psbt_mem_i (
      .clk(clk), .resetn(resetn), .bus(psbt_if_i), .cfg_word(cfg_word),
      .refresh_pending(refresh_pending));
   psbt_props #(.MAX_LOW(MAX_SEL_LOW_CYC)) psbt_props_i (
      .clk(clk), .resetn(resetn), .select_n(psbt_if_i.select_n),
      .address_valid_n(psbt_if_i.address_valid_n), .write_n(psbt_if_i.write_n),
      .clk_run(psbt_if_i.clk_run), .wait_n(psbt_if_i.wait_n));
   task chk(input string what, input logic [31:0] e, input logic [31:0] g);
      num_checks++;
      if (g !== e) begin
         err_total++;
         $display("wrong value %s expected %h seen %h", what, e, g);
      end
   endtask : chk
   // Called just after a rising edge; returns one edge after the answer
   task av(input logic wr, input logic [4:0] a, input logic [31:0] d, output logic [31:0] v);
      int n;
      n = 0;
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= !wr;
      do begin
         @(posedge clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 500);
      if (n >= 500) err_total++;
      v = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      @(posedge clk);
   endtask : av
   task wreg(input logic [4:0] a, input logic [31:0] d);
      logic [31:0] t;
      av(1'b1, a, d, t);
   endtask : wreg
   task idle;
      logic [31:0] s;
      int k;
      k = 0;
      do begin
         av(1'b0, REG_STATUS, 32'h0, s);
         k++;
      end while ((s[0] | s[2] | s[3] | s[4]) !== 1'b0 && k < 400);
      if (k >= 400) err_total++;
   endtask : idle
   task wrap_up;
      $display("checks %0d errors %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : wrap_up
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   initial begin
      repeat (40000) @(posedge clk);
      err_total++;
      wrap_up();
   end
   initial begin
      err_total = 0;
      num_checks = 0;
      resetn = 1'b0;
      avs_address = 5'h00;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h0;
      repeat (3) @(posedge clk);
      resetn <= 1'b1;
      @(posedge clk);
      chk("waitrequest", 32'h1, {31'h0, avs_waitrequest});
      chk("select", 32'h1, {31'h0, psbt_if_i.select_n});
      chk("config word", 32'h9000, {16'h0, cfg_word});
      chk("refresh pending", 32'h0, {31'h0, refresh_pending});
      av(1'b0, REG_CONFIG, 32'h0, q);
      chk("config reg", 32'h9000, q);
      av(1'b0, REG_LEN, 32'h0, q);
      chk("length reg", 32'h4, q);
      av(1'b0, 5'h1c, 32'h0, q);
      chk("unmapped", 32'h0, q);
      // Asynchronous, variable latency, code two
      wreg(REG_CONFIG, 32'h1000);
      idle();
      chk("config word", 32'h1000, {16'h0, cfg_word});
      for (int i = 0; i < 20; i++) begin
         // Fixed latency lets asynchronous writes chain; the last pair runs in sync mode
         if (i == 9 || i == 18) begin
            wreg(REG_CONFIG, (i == 9) ? 32'h5000 : 32'h9000);
            idle();
         end
         // Only CTRL follows a go_on row, so it lands before that command's first word
         if (r.go_on !== 1'b1) begin
            wreg(REG_ADDR, {10'h000, rows[i].addr});
            wreg(REG_WDATA, {16'h0000, rows[i].wdata});
            wreg(REG_LEN, {24'h0, rows[i].len});
         end
         r = rows[i];
         wreg(REG_CTRL, {24'h0, r.ctrl});
         if (!r.go_on) begin
            idle();
            if (^r.ctrl[1:0]) begin
               av(1'b0, REG_RDATA, 32'h0, q);
               chk("read word", {16'h0000, r.exp}, q);
            end
         end
      end
      // Idle link: one refresh demand per period, dropped again while select is high
      pulses = 0;
      repeat (2 * REFRESH_PERIOD_CYC) begin
         @(posedge clk);
         if (refresh_pending === 1'b1) pulses++;
      end
      chk("refresh pulses", 32'h2, pulses);
      wrap_up();
   end
endmodule : psbt_burst_transition_rules_bench

// ---- verification/psbt_props.sv ----
// Concurrent checks on the controller to memory link
`timescale 1ns/100ps
module psbt_props #(
   parameter int MAX_LOW = psbt_pkg::MAX_SEL_LOW_CYC
) (
   // Clock and reset
   input wire logic clk,
   input wire logic resetn,
   // Link signals
   input wire logic select_n,
   input wire logic address_valid_n,
   input wire logic write_n,
   input wire logic clk_run,
   input wire logic wait_n
);
   import psbt_pkg::*;
   logic [15:0] low_cnt_q;
   logic [15:0] low_cnt_d;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!resetn);
   // Wide counter so a stuck select cannot wrap back under the limit
   always_comb begin
      low_cnt_d = select_n ? 16'h0000 : low_cnt_q + 16'h0001;
   end
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         low_cnt_q <= 16'h0000;
      end else begin
         low_cnt_q <= low_cnt_d;
      end
   end
   sequence s_addr;
      !select_n && !address_valid_n && clk_run;
   endsequence
   sequence s_stall;
      // Three clocks for code two, up to six on a refresh collision
      !wait_n [*3] ##[1:4] $rose(wait_n);
   endsequence
   property p_sel_max;
      !select_n |-> low_cnt_q < MAX_LOW;
   endproperty
   property p_split;
      low_cnt_q >= MAX_LOW - 2 * SEL_LOW_MARGIN |-> ##[0:4] select_n;
   endproperty
   property p_lat;
      s_addr |=> s_stall;
   endproperty
   property p_wr_stall;
      s_addr ##0 !write_n |=> !wait_n ##1 !wait_n;
   endproperty
   property p_adv_pulse;
      s_addr |=> address_valid_n;
   endproperty
   property p_intr;
      !address_valid_n && clk_run && !select_n && $past(!select_n) && $past(clk_run)
         |-> $past(wait_n);
   endproperty
   property p_into_burst;
      !select_n && $past(!select_n) && $rose(clk_run) |-> write_n;
   endproperty
   property p_out_burst;
      !select_n && $past(!select_n) && $fell(clk_run) |-> !write_n;
   endproperty
   a_sel_max: assert property (p_sel_max)
      else $error("select held low too long");
   a_split: assert property (p_split)
      else $error("long transfer not split");
   a_lat: assert property (p_lat)
      else $error("stall length wrong");
   a_wr_stall: assert property (p_wr_stall)
      else $error("write burst stall wrong");
   a_adv_pulse: assert property (p_adv_pulse)
      else $error("address valid not a single cycle");
   a_intr: assert property (p_intr)
      else $error("burst interrupted before first word");
   a_into_burst: assert property (p_into_burst)
      else $error("illegal chain into burst");
   a_out_burst: assert property (p_out_burst)
      else $error("illegal chain out of burst");
endmodule : psbt_props
